// File: design/load_adaptive_pkg.sv
package load_adaptive_pkg;
  // ---------------------------------------------------------------
  // register selection, bits 19..17 of a 20-bit word
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 20;
  localparam logic [2:0] SEL_CHOPPER = 3'h4;
  localparam logic [2:0] SEL_ADAPTIVE = 3'h5;
  localparam logic [2:0] SEL_LOAD_CS = 3'h6;
  localparam int unsigned SEL_MSB = 19;
  localparam int unsigned SEL_LSB = 17;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned OFF_TIME_LSB = 0;
  localparam int unsigned BLANK_LSB = 15;
  localparam int unsigned MIN_LSB = 0;
  localparam int unsigned INC_LSB = 5;
  localparam int unsigned MAX_LSB = 8;
  localparam int unsigned DEC_LSB = 13;
  localparam int unsigned IMIN_BIT = 15;
  localparam int unsigned CS_LSB = 0;
  localparam int unsigned THR_LSB = 8;
  localparam int unsigned FILT_BIT = 16;

  // ---------------------------------------------------------------
  // timing and scaling
  // ---------------------------------------------------------------
  localparam int unsigned OFF_BASE = 24;
  localparam int unsigned OFF_STEP = 32;
  localparam int unsigned THR_STEP = 32;
  localparam int unsigned CS_DIV = 32;
  localparam int unsigned FILT_STEPS = 4;
  localparam int unsigned DEC_CNT_SLOW = 32;
  localparam int unsigned DEC_CNT_MID = 8;
  localparam int unsigned DEC_CNT_FAST = 2;
  localparam int unsigned DEC_CNT_EVERY = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_OFF_TIME = 4'h0;
  localparam logic [4:0] RST_CS = 5'h1f;

  typedef struct packed {
    logic [1:0] blank_time;
    logic [3:0] off_time;
  } chopper_cfg_t;

  typedef struct packed {
    logic minimum_current_select;
    logic [1:0] decrement_rate;
    logic [3:0] upper_threshold_offset;
    logic [1:0] increment_size;
    logic [3:0] lower_load_threshold;
  } adaptive_cfg_t;

  typedef struct packed {
    logic load_filter_enable;
    logic signed [6:0] load_threshold;
    logic [4:0] current_scale;
  } load_cs_cfg_t;
endpackage : load_adaptive_pkg

// File: design/off_time_timer.sv
`timescale 1ns/1ps
module off_time_timer
  import load_adaptive_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic [3:0] off_time,
  input wire logic start,
  // status
  output logic bridges_enable,
  output logic slow_decay
);
  logic [9:0] count;
  wire [9:0] load_value = 10'(OFF_BASE) + 10'(OFF_STEP) * {6'h0, off_time};
  wire disabled = (off_time == RST_OFF_TIME);

  // ---------------------------------------------------------------
  // slow decay counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 10'h0;
    end else if (disabled) begin
      count <= 10'h0;
    end else if (start && count == 10'h0) begin
      count <= load_value;
    end else if (count != 10'h0) begin
      count <= count - 10'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bridges_enable <= 1'b0;
    end else begin
      bridges_enable <= !disabled;
    end
  end

  assign slow_decay = (count != 10'h0);
endmodule : off_time_timer

// File: design/load_adaptive_current_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// - off-time zero turns all bridges off
// - slow decay lasts 24 plus 32 times field
// - lower threshold zero disables current regulation
// - load below lower times 32 raises current
// - raise steps 1, 2, 4 or 8
// - upper threshold is (lower+offset+1) times 32
// - lower by one after 32, 8, 2, 1
// - floor is half or quarter of scale
// - filter clear passes every load sample
// - filter set samples once per four steps
// - load threshold is signed seven bits
// - lower threshold flags stall with less torque
// - coil currents scaled by (adaptive factor+1)/32
module load_adaptive_current_config
  import load_adaptive_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial host words, already assembled
  input wire logic [19:0] write_word,
  input wire logic write_valid,
  // load measurement side
  input wire logic [9:0] load_measurement,
  input wire logic load_sample,
  input wire logic full_step,
  input wire logic signed [9:0] stall_level,
  // chopper side
  input wire logic chop_start,
  // coil currents
  input wire logic [7:0] coil_a_in,
  input wire logic [7:0] coil_b_in,
  // outputs
  output logic [7:0] coil_a_out,
  output logic [7:0] coil_b_out,
  output logic [4:0] current_factor,
  output logic stall_indicator_output,
  output logic bridges_enable,
  output logic slow_decay,
  output logic [1:0] blank_time
);
  chopper_cfg_t chop;
  adaptive_cfg_t adapt;
  load_cs_cfg_t lcs;
  logic [9:0] load_held;
  logic [1:0] step_count;
  logic load_update;
  logic [5:0] dec_count;
  logic [4:0] factor;

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  // unknown selectors fall through and change nothing
  wire [2:0] sel = write_word[SEL_MSB:SEL_LSB];
  wire wr_chop = write_valid && sel == SEL_CHOPPER;
  wire wr_adapt = write_valid && sel == SEL_ADAPTIVE;
  wire wr_lcs = write_valid && sel == SEL_LOAD_CS;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chop <= '0;
      adapt <= '0;
      lcs <= '{1'b0, 7'sh00, RST_CS};
    end else begin
      if (wr_chop) begin
        chop.off_time <= write_word[OFF_TIME_LSB+:4];
        chop.blank_time <= write_word[BLANK_LSB+:2];
      end
      if (wr_adapt) begin
        adapt.lower_load_threshold <= write_word[MIN_LSB+:4];
        adapt.increment_size <= write_word[INC_LSB+:2];
        adapt.upper_threshold_offset <= write_word[MAX_LSB+:4];
        adapt.decrement_rate <= write_word[DEC_LSB+:2];
        adapt.minimum_current_select <= write_word[IMIN_BIT];
      end
      if (wr_lcs) begin
        lcs.current_scale <= write_word[CS_LSB+:5];
        lcs.load_threshold <= write_word[THR_LSB+:7];
        lcs.load_filter_enable <= write_word[FILT_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // load filter
  // ---------------------------------------------------------------
  // filtered mode holds the sample, so regulation reacts slower
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_count <= 2'h0;
      load_held <= 10'h0;
      load_update <= 1'b0;
    end else begin
      load_update <= 1'b0;
      if (full_step) begin
        step_count <= step_count + 2'h1;
      end
      if (!lcs.load_filter_enable && load_sample) begin
        load_held <= load_measurement;
        load_update <= 1'b1;
      end else if (lcs.load_filter_enable && full_step &&
                   step_count == 2'(FILT_STEPS - 1)) begin
        load_held <= load_measurement;
        load_update <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // stall indication
  // ---------------------------------------------------------------
  wire signed [9:0] thr_ext = 10'(lcs.load_threshold);
  wire signed [10:0] stall_cmp = 11'(stall_level) - 11'(thr_ext);
  // level counts up with torque, so a smaller threshold trips sooner
  assign stall_indicator_output = !stall_cmp[10];

  // ---------------------------------------------------------------
  // decrement sample counts
  // ---------------------------------------------------------------
  // counter compares against the count minus one
  function automatic logic [5:0] dec_limit(input logic [1:0] code);
    unique case (code)
      2'h0: dec_limit = 6'(DEC_CNT_SLOW - 1);
      2'h1: dec_limit = 6'(DEC_CNT_MID - 1);
      2'h2: dec_limit = 6'(DEC_CNT_FAST - 1);
      2'h3: dec_limit = 6'(DEC_CNT_EVERY - 1);
    endcase
  endfunction : dec_limit

  // ---------------------------------------------------------------
  // regulator thresholds and limits
  // ---------------------------------------------------------------
  wire regulate = adapt.lower_load_threshold != 4'h0;
  wire [9:0] lower_thr = 10'(THR_STEP) *
    {6'h0, adapt.lower_load_threshold};
  wire [10:0] upper_thr = 11'(THR_STEP) *
    (11'(adapt.lower_load_threshold) +
     11'(adapt.upper_threshold_offset) + 11'h1);
  wire below = load_held < lower_thr;
  wire at_above = {1'b0, load_held} >= upper_thr;
  wire [3:0] inc_steps = 4'h1 << adapt.increment_size;
  wire [5:0] dec_need = dec_limit(adapt.decrement_rate);
  wire [4:0] floor_val = adapt.minimum_current_select ?
    (lcs.current_scale >> 2) : (lcs.current_scale >> 1);
  wire [5:0] raised = 6'(factor) + 6'(inc_steps);
  wire [4:0] next_up = (raised > 6'(lcs.current_scale)) ?
    lcs.current_scale : raised[4:0];
  wire [4:0] next_down = (factor > floor_val) ?
    factor - 5'h1 : floor_val;

  // ---------------------------------------------------------------
  // adaptive current factor
  // ---------------------------------------------------------------
  // ceiling check first, so a lowered scale pulls the factor down
  // decrement count restarts on each raise, trading speed for calm
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      factor <= RST_CS;
      dec_count <= 6'h0;
    end else if (!regulate) begin
      factor <= lcs.current_scale;
      dec_count <= 6'h0;
    end else if (factor > lcs.current_scale) begin
      factor <= lcs.current_scale;
    end else if (load_update && below) begin
      factor <= next_up;
      dec_count <= 6'h0;
    end else if (load_update && at_above) begin
      if (dec_count >= dec_need) begin
        factor <= next_down;
        dec_count <= 6'h0;
      end else begin
        dec_count <= dec_count + 6'h1;
      end
    end
  end
  assign current_factor = factor;

  // ---------------------------------------------------------------
  // coil current scaling
  // ---------------------------------------------------------------
  // product keeps bits 12:5, so factor 31 passes a coil value whole
  function automatic logic [7:0] scale_coil(input logic [7:0] v,
                                            input logic [4:0] f);
    logic [13:0] p;
    p = 14'(v) * (14'(f) + 14'h1);
    scale_coil = p[12:5];
  endfunction : scale_coil

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coil_a_out <= 8'h0;
      coil_b_out <= 8'h0;
    end else begin
      coil_a_out <= scale_coil(coil_a_in, factor);
      coil_b_out <= scale_coil(coil_b_in, factor);
    end
  end

  // ---------------------------------------------------------------
  // off-time and blanking
  // ---------------------------------------------------------------
  // host must pair off-time one with blanking of 24 or more
  assign blank_time = chop.blank_time;

  off_time_timer u_off (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .off_time(chop.off_time),
    .start(chop_start),
    .bridges_enable(bridges_enable),
    .slow_decay(slow_decay)
  );
endmodule : load_adaptive_current_config

// File: test/host_model.sv
`timescale 1ns/1ps
module host_model
  import load_adaptive_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // host word
  output logic [19:0] write_word,
  output logic write_valid
);
  initial begin
    write_word = 20'h00000;
    write_valid = 1'b0;
  end
  // released word is inverted, never left stale
  task automatic send(input logic [2:0] sel, input logic [16:0] f);
    if (sel == SEL_CHOPPER && f[3:0] == 4'h1 && f[16:15] == 2'h0)
      f[16:15] = 2'h1;
    if (sel == SEL_LOAD_CS && $signed(f[14:8]) < -7'sd10)
      f[14:8] = 7'h76;
    @(negedge clk_sys);
    write_word = {sel, f};
    write_valid = 1'b1;
    @(negedge clk_sys);
    write_word = ~write_word;
    write_valid = 1'b0;
  endtask : send
endmodule : host_model

// File: test/load_adaptive_chk.sv
`timescale 1ns/1ps
module load_adaptive_chk
  import load_adaptive_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // inputs
  input wire logic [19:0] write_word,
  input wire logic write_valid,
  input wire logic [9:0] load_measurement,
  input wire logic load_sample,
  input wire logic signed [9:0] stall_level,
  // outputs
  input wire logic [4:0] current_factor,
  input wire logic stall_indicator_output,
  input wire logic bridges_enable,
  input wire logic slow_decay,
  input wire logic [1:0] blank_time
);
  // ----
  // shadow fields
  // ----
  logic [16:0] adp;
  logic [16:0] lcs;
  logic [3:0] off;
  logic [9:0] run;
  logic [4:0] expf;
  wire [2:0] sel = write_word[19:17];
  wire [4:0] cs = lcs[4:0];
  wire [3:0] lo = adp[3:0];
  wire signed [6:0] thr = lcs[14:8];
  wire [4:0] flr = adp[15] ? cs >> 2 : cs >> 1;
  wire [5:0] up = current_factor + (6'h1 << adp[6:5]);
  wire [4:0] raised = up > cs ? cs : up[4:0];
  wire [4:0] lowered = current_factor > flr ? current_factor - 5'h1 : flr;
  wire [9:0] upper = ({6'h0, lo} + adp[11:8] + 10'h1) << 5;
  // filtered updates are judged by the bench
  wire act = load_sample && !lcs[16] && lo != 4'h0;
  wire below = act && load_measurement < {lo, 5'h00};
  wire above = act && adp[14:13] == 2'h3 && load_measurement >= upper;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adp <= 17'h00000;
      lcs <= 17'h0001f;
      off <= 4'h0;
      run <= 10'h000;
      expf <= 5'h1f;
    end else begin
      run <= slow_decay ? run + 10'h001 : 10'h000;
      if (write_valid && sel == SEL_ADAPTIVE) adp <= write_word[16:0];
      if (write_valid && sel == SEL_LOAD_CS) lcs <= write_word[16:0];
      if (write_valid && sel == SEL_CHOPPER) off <= write_word[3:0];
      if (below) expf <= raised;
      else if (above) expf <= lowered;
    end
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  blank_take_a: assert property (
    write_valid && sel == SEL_CHOPPER
    |=> blank_time == $past(write_word[16:15])) else $error("blank wrong");
  bridge_gate_a: assert property (
    write_valid && sel == SEL_CHOPPER |-> ##2
    bridges_enable == ($past(write_word[3:0], 2) != 4'h0))
    else $error("bridge enable wrong");
  decay_off_a: assert property (!bridges_enable |-> !slow_decay)
    else $error("decay while off");
  decay_len_a: assert property (
    $fell(slow_decay) && off != 4'h0 |-> run == 10'd24 + 10'd32 * off)
    else $error("decay length wrong");
  raise_step_a: assert property (
    below |-> ##[2:3] current_factor == expf) else $error("raise wrong");
  drop_step_a: assert property (
    above |-> ##[2:3] current_factor == expf) else $error("drop wrong");
  follow_cs_a: assert property (
    lo == 4'h0 && $past(lo, 2) == 4'h0 && $past(cs, 2) == cs
    |-> current_factor == cs) else $error("factor not scale");
  stall_cmp_a: assert property (
    stall_indicator_output == (stall_level >= thr)) else $error("stall wrong");
  cover property (below);
  cover property (above);
  cover property ($fell(slow_decay));
endmodule : load_adaptive_chk

bind load_adaptive_current_config load_adaptive_chk u_chk (
  .clk_sys, .rst_n, .write_word, .write_valid, .load_measurement,
  .load_sample, .stall_level, .current_factor, .stall_indicator_output,
  .bridges_enable, .slow_decay, .blank_time);

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench
  import load_adaptive_pkg::*;
;
  logic clk_sys, rst_n, load_sample, full_step, chop_start, write_valid;
  logic stall_indicator_output, bridges_enable, slow_decay;
  logic [19:0] write_word;
  logic [9:0] load_measurement;
  logic signed [9:0] stall_level;
  logic [7:0] coil_a_in, coil_b_in, coil_a_out, coil_b_out;
  logic [4:0] current_factor;
  logic [1:0] blank_time;
  logic [38:0] rows [4];
  int dn [4] = '{32, 8, 2, 1};
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  host_model host (.clk_sys, .write_word, .write_valid);
  load_adaptive_current_config DUT (.clk_sys, .rst_n, .write_word,
    .write_valid, .load_measurement, .load_sample, .full_step,
    .stall_level, .chop_start, .coil_a_in, .coil_b_in, .coil_a_out,
    .coil_b_out, .current_factor, .stall_indicator_output,
    .bridges_enable, .slow_decay, .blank_time);
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : tick
  // factor settles within three edges of a strobe
  task automatic sample(input logic [9:0] v, input int k, input logic fs);
    repeat (k) begin
      load_measurement = v;
      load_sample = !fs;
      full_step = fs;
      tick(1);
      load_sample = 1'b0;
      full_step = 1'b0;
      tick(3);
    end
  endtask : sample
  task automatic adapt(input logic [1:0] inc, dec, input logic imin);
    host.send(SEL_ADAPTIVE, {1'b0, imin, dec, 6'h00, inc, 5'h01});
  endtask : adapt
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    load_sample = 1'b0;
    full_step = 1'b0;
    chop_start = 1'b0;
    load_measurement = 10'h000;
    stall_level = 10'h000;
    coil_a_in = 8'h00;
    coil_b_in = 8'h00;
    rows[0] = {5'h00, 7'h00, 8'hff, 10'h000, 8'h07, 1'b1};
    rows[1] = {5'h1f, 7'h7f, 8'hff, 10'h3fe, 8'hff, 1'b0};
    rows[2] = {5'h14, 7'h3f, 8'h80, 10'h03f, 8'h54, 1'b1};
    rows[3] = {5'h0f, 7'h76, 8'hff, 10'h3f5, 8'h7f, 1'b0};
    tick(5);
    rst_n = 1'b1;
    check(bridges_enable, 10'h000);
    check(current_factor, 10'h01f);
    for (int i = 0; i < 4; i++) begin
      host.send(SEL_LOAD_CS, {2'h0, rows[i][33:27], 3'h0, rows[i][38:34]});
      coil_a_in = rows[i][26:19];
      coil_b_in = rows[i][26:19];
      stall_level = rows[i][18:9];
      tick(4);
      check(coil_a_out, rows[i][8:1]);
      check(coil_b_out, rows[i][8:1]);
      check(stall_indicator_output, rows[i][0]);
      check(current_factor, rows[i][38:34]);
    end
    for (int k = 1; k < 16; k += 14) begin
      host.send(SEL_CHOPPER, {2'h1, 11'h000, k[3:0]});
      chop_start = 1'b1;
      tick(1);
      chop_start = 1'b0;
      check(bridges_enable, 10'h001);
      check(blank_time, 10'h001);
      n = 0;
      while (slow_decay === 1'b1 && n < 600) begin
        n++;
        tick(1);
      end
      check(n[9:0], 10'(24 + 32 * k));
      if (n == 600) stop_test();
    end
    host.send(SEL_CHOPPER, 17'h08000);
    chop_start = 1'b1;
    tick(1);
    chop_start = 1'b0;
    check(bridges_enable, 10'h000);
    check(slow_decay, 10'h000);
    // unused selector must leave the blanking field alone
    host.send(3'h7, 17'h1ffff);
    check(blank_time, 10'h001);
    host.send(SEL_LOAD_CS, 17'h00010);
    for (int c = 0; c < 4; c++) begin
      adapt(c[1:0], 2'h3, 1'b1);
      sample(10'd64, 14, 1'b0);
      check(current_factor, 10'h004);
      sample(10'd31, 1, 1'b0);
      check(current_factor, 10'(4 + (1 << c)));
    end
    sample(10'd31, 1, 1'b0);
    check(current_factor, 10'h010);
    sample(10'd32, 1, 1'b0);
    sample(10'd63, 1, 1'b0);
    check(current_factor, 10'h010);
    adapt(2'h0, 2'h3, 1'b0);
    sample(10'd64, 10, 1'b0);
    check(current_factor, 10'h008);
    for (int d = 0; d < 4; d++) begin
      adapt(2'h0, d[1:0], 1'b0);
      sample(10'd31, 1, 1'b0);
      sample(10'd64, dn[d] - 1, 1'b0);
      check(current_factor, 10'h009);
      sample(10'd64, 1, 1'b0);
      check(current_factor, 10'h008);
    end
    host.send(SEL_LOAD_CS, 17'h10010);
    adapt(2'h0, 2'h3, 1'b0);
    sample(10'd31, 2, 1'b0);
    check(current_factor, 10'h008);
    sample(10'd31, 3, 1'b1);
    check(current_factor, 10'h008);
    sample(10'd31, 1, 1'b1);
    check(current_factor, 10'h009);
    host.send(SEL_ADAPTIVE, 17'h00000);
    tick(3);
    check(current_factor, 10'h010);
    // reset in mid-run, just after a decay has started
    host.send(SEL_CHOPPER, 17'h0800f);
    chop_start = 1'b1;
    tick(1);
    chop_start = 1'b0;
    check(slow_decay, 10'h001);
    rst_n = 1'b0;
    tick(1);
    check(slow_decay, 10'h000);
    check(bridges_enable, 10'h000);
    check(blank_time, 10'h000);
    check(current_factor, 10'h01f);
    check(coil_a_out, 10'h000);
    tick(4);
    rst_n = 1'b1;
    tick(2);
    check(bridges_enable, 10'h000);
    check(current_factor, 10'h01f);
    stop_test();
  end
endmodule : testbench
